// ===== design/channel_eq_driver_control_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Force-one bit of signal-detect config makes the detect result one.
// - Force-zero bit makes the detect result zero unless force-one is set; both clear means normal detection.
// - Signal-detect config holds assert threshold 5:4, de-assert 3:2, reset 0x04.
// - Driver control bits 7:6 are output swing, reset 11, register reset 0xC0.
// - Power override set: manual power-down bits; clear: power down on signal loss.
// - Mute override set: manual mute bit; clear: mute on signal loss.
// - Manual mute acts only while mute override is set.
// - Driver power-down bit powers down driver while power override is set; clear keeps it powered.
// - Driver control bit 2 disables the common-mode loop.
// - Driver control bit 0 selects limiting mode, zero linear mode.
// - Equalizer gain select bit 5: one high gain, zero low gain, resets zero.
// - Stage-one bypass bit 0 routes signal around the first boost stage.
// - Bias code is three bits: MSB in equalizer control bit 1, low bits external.
// - Status register bit 7 reads one while a signal is detected.

module channel_eq_driver_control_regs (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          nrst,
  // Management bus register port
  input  wire channel_ctrl_pkg::reg_write_t  mgmt_write,
  input  wire logic [7:0]                    read_addr,
  output logic [7:0]                         read_data,
  // EEPROM load port
  input  wire channel_ctrl_pkg::reg_write_t  eeprom_write,
  // Analog side
  input  wire logic                          raw_detect,
  input  wire logic [7:0]                    bias_trim_high,
  output channel_ctrl_pkg::analog_ctrl_t     analog_ctrl,
  output logic                               signal_present_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0]                     equalizer_control;
  logic [7:0]                     signal_detect_config;
  logic [7:0]                     driver_control;
  logic [7:0]                     reserved_seven;
  logic [7:0]                     bias_trim_control;
  channel_ctrl_pkg::reg_write_t   write_req;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic hits(
    input channel_ctrl_pkg::reg_write_t w,
    input logic [7:0]                   offset
  );
    hits = w.valid && (w.addr == offset);
  endfunction : hits

  // Manual value while its override is set, automatic value otherwise
  function automatic logic pick(
    input logic override,
    input logic manual,
    input logic auto_value
  );
    if (override) begin
      pick = manual;
    end else begin
      pick = auto_value;
    end
  endfunction : pick

  ////////////////////////////////////////////////////////////////////////////
  // Write arbitration

  // Management bus wins over a simultaneous EEPROM load; the load is dropped
  always_comb begin
    write_req = eeprom_write;
    if (mgmt_write.valid) begin
      write_req = mgmt_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      equalizer_control <= channel_ctrl_pkg::eq_control_reset;
    end else begin
      if (hits(write_req, channel_ctrl_pkg::eq_control_offset)) begin
        equalizer_control <= write_req.data;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      signal_detect_config <= channel_ctrl_pkg::sd_config_reset;
    end else begin
      if (hits(write_req, channel_ctrl_pkg::sd_config_offset)) begin
        signal_detect_config <= write_req.data;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      driver_control <= channel_ctrl_pkg::drv_control_reset;
    end else begin
      if (hits(write_req, channel_ctrl_pkg::drv_control_offset)) begin
        driver_control <= write_req.data;
      end
    end
  end

  // Reserved byte is plain storage so it reads back as written
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reserved_seven <= channel_ctrl_pkg::reserved_reset;
    end else begin
      if (hits(write_req, channel_ctrl_pkg::reserved_offset)) begin
        reserved_seven <= write_req.data;
      end
    end
  end

  // Trim byte is only stored here; its fields steer nothing in this slice
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bias_trim_control <= channel_ctrl_pkg::bias_trim_reset;
    end else begin
      if (hits(write_req, channel_ctrl_pkg::bias_trim_offset)) begin
        bias_trim_control <= write_req.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signal detect

  logic detect_result;
  logic no_input_signal;

  // Force-one takes precedence if software sets both, as a safe default
  always_comb begin
    detect_result = raw_detect;
    if (signal_detect_config[channel_ctrl_pkg::detect_force_one_bit]) begin
      detect_result = 1'b1;
    end else if (signal_detect_config[channel_ctrl_pkg::detect_force_zero_bit]) begin
      detect_result = 1'b0;
    end
  end

  assign no_input_signal = !detect_result;

  ////////////////////////////////////////////////////////////////////////////
  // Equalizer fields

  logic       next_eq_gain_select;
  logic       next_stage_one_bypass;
  logic [2:0] next_equalizer_bias_code;

  always_comb begin
    next_eq_gain_select      = equalizer_control[channel_ctrl_pkg::eq_gain_select_bit];
    next_stage_one_bypass    = equalizer_control[channel_ctrl_pkg::stage_one_bypass_bit];
    // Low bias pair lives outside this slice and arrives unregistered
    next_equalizer_bias_code = {equalizer_control[channel_ctrl_pkg::eq_bias_msb_bit],
                                bias_trim_high[channel_ctrl_pkg::bias_low_hi:
                                               channel_ctrl_pkg::bias_low_lo]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signal detect thresholds

  logic [1:0] next_detect_assert_threshold;
  logic [1:0] next_detect_deassert_threshold;

  always_comb begin
    next_detect_assert_threshold   = signal_detect_config[channel_ctrl_pkg::assert_threshold_hi:
                                                          channel_ctrl_pkg::assert_threshold_lo];
    next_detect_deassert_threshold = signal_detect_config[channel_ctrl_pkg::deassert_threshold_hi:
                                                          channel_ctrl_pkg::deassert_threshold_lo];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver static fields

  logic [1:0] next_output_swing;
  logic       next_common_mode_loop_disable;
  logic       next_limiting_mode_select;

  // Swing applies in both linear and limiting modes
  always_comb begin
    next_output_swing             = driver_control[channel_ctrl_pkg::output_swing_hi:
                                                   channel_ctrl_pkg::output_swing_lo];
    next_common_mode_loop_disable = driver_control[channel_ctrl_pkg::cm_loop_disable_bit];
    next_limiting_mode_select     = driver_control[channel_ctrl_pkg::limiting_mode_bit];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power and mute

  logic next_driver_power_down;
  logic next_equalizer_power_down;
  logic next_driver_mute;

  // Both power-downs share one override; automatic mode follows loss of signal
  always_comb begin
    next_driver_power_down    = pick(driver_control[channel_ctrl_pkg::power_override_bit],
                                     driver_control[channel_ctrl_pkg::driver_power_down_bit],
                                     no_input_signal);
    next_equalizer_power_down = pick(driver_control[channel_ctrl_pkg::power_override_bit],
                                     equalizer_control[channel_ctrl_pkg::eq_power_down_bit],
                                     no_input_signal);
  end

  // Manual mute is ignored unless the override is set
  always_comb begin
    next_driver_mute = pick(driver_control[channel_ctrl_pkg::mute_override_bit],
                            driver_control[channel_ctrl_pkg::manual_mute_bit],
                            no_input_signal);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output packing

  channel_ctrl_pkg::analog_ctrl_t next_analog_ctrl;

  always_comb begin
    next_analog_ctrl                           = channel_ctrl_pkg::analog_ctrl_reset;
    next_analog_ctrl.eq_gain_select            = next_eq_gain_select;
    next_analog_ctrl.equalizer_power_down      = next_equalizer_power_down;
    next_analog_ctrl.equalizer_bias_code       = next_equalizer_bias_code;
    next_analog_ctrl.stage_one_bypass          = next_stage_one_bypass;
    next_analog_ctrl.detect_assert_threshold   = next_detect_assert_threshold;
    next_analog_ctrl.detect_deassert_threshold = next_detect_deassert_threshold;
    next_analog_ctrl.output_swing              = next_output_swing;
    next_analog_ctrl.driver_power_down         = next_driver_power_down;
    next_analog_ctrl.driver_mute               = next_driver_mute;
    next_analog_ctrl.common_mode_loop_disable  = next_common_mode_loop_disable;
    next_analog_ctrl.limiting_mode_select      = next_limiting_mode_select;
  end

  // Registered so the analog controls never glitch on a write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      analog_ctrl <= channel_ctrl_pkg::analog_ctrl_reset;
    end else begin
      analog_ctrl <= next_analog_ctrl;
    end
  end

  // Status flop has the same latency as the analog controls
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      signal_present_status <= 1'b0;
    end else begin
      signal_present_status <= detect_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] next_read_data;

  // Writes to the status offset miss every register and are lost
  always_comb begin
    next_read_data = channel_ctrl_pkg::unmapped_read;
    unique case (read_addr)
      channel_ctrl_pkg::signal_status_offset: begin
        next_read_data[channel_ctrl_pkg::signal_present_bit] = detect_result;
      end
      channel_ctrl_pkg::eq_control_offset: begin
        next_read_data = equalizer_control;
      end
      channel_ctrl_pkg::sd_config_offset: begin
        next_read_data = signal_detect_config;
      end
      channel_ctrl_pkg::drv_control_offset: begin
        next_read_data = driver_control;
      end
      channel_ctrl_pkg::reserved_offset: begin
        next_read_data = reserved_seven;
      end
      channel_ctrl_pkg::bias_trim_offset: begin
        next_read_data = bias_trim_control;
      end
      default: begin
        next_read_data = channel_ctrl_pkg::unmapped_read;
      end
    endcase
  end

  // Read answer lands one edge after the address is sampled
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_data <= channel_ctrl_pkg::unmapped_read;
    end else begin
      read_data <= next_read_data;
    end
  end

endmodule : channel_eq_driver_control_regs

// ===== shared/channel_ctrl_pkg.sv
package channel_ctrl_pkg;

  // Register offsets
  localparam logic [7:0] signal_status_offset = 8'h01;
  localparam logic [7:0] eq_control_offset    = 8'h04;
  localparam logic [7:0] sd_config_offset     = 8'h05;
  localparam logic [7:0] drv_control_offset   = 8'h06;
  localparam logic [7:0] reserved_offset      = 8'h07;
  localparam logic [7:0] bias_trim_offset     = 8'h08;

  // Reset values
  localparam logic [7:0] eq_control_reset     = 8'h90;
  localparam logic [7:0] sd_config_reset      = 8'h04;
  localparam logic [7:0] drv_control_reset    = 8'hC0;
  localparam logic [7:0] reserved_reset       = 8'h20;
  localparam logic [7:0] bias_trim_reset      = 8'h54;
  localparam logic [7:0] unmapped_read        = 8'h00;

  // Equalizer control fields
  localparam int eq_gain_select_bit       = 5;
  localparam int eq_power_down_bit        = 3;
  localparam int eq_bias_msb_bit          = 1;
  localparam int stage_one_bypass_bit     = 0;

  // Signal detect config fields
  localparam int detect_force_one_bit     = 7;
  localparam int detect_force_zero_bit    = 6;
  localparam int assert_threshold_hi      = 5;
  localparam int assert_threshold_lo      = 4;
  localparam int deassert_threshold_hi    = 3;
  localparam int deassert_threshold_lo    = 2;

  // Driver control fields
  localparam int output_swing_hi          = 7;
  localparam int output_swing_lo          = 6;
  localparam int power_override_bit       = 5;
  localparam int mute_override_bit        = 4;
  localparam int driver_power_down_bit    = 3;
  localparam int cm_loop_disable_bit      = 2;
  localparam int manual_mute_bit          = 1;
  localparam int limiting_mode_bit        = 0;

  // Status field
  localparam int signal_present_bit       = 7;

  // Bias low bits held in the neighbouring trim register
  localparam int bias_low_hi              = 5;
  localparam int bias_low_lo              = 4;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic       eq_gain_select;
    logic       equalizer_power_down;
    logic [2:0] equalizer_bias_code;
    logic       stage_one_bypass;
    logic [1:0] detect_assert_threshold;
    logic [1:0] detect_deassert_threshold;
    logic [1:0] output_swing;
    logic       driver_power_down;
    logic       driver_mute;
    logic       common_mode_loop_disable;
    logic       limiting_mode_select;
  } analog_ctrl_t;

  localparam analog_ctrl_t analog_ctrl_reset = '0;

endpackage : channel_ctrl_pkg

// ===== dv/channel_regs_chk.sv
`timescale 1ns/100ps
module channel_regs_chk (
  // Clock and reset
  input wire logic                          clock,
  input wire logic                          nrst,
  // Register and analog side
  input wire logic [7:0]                    read_addr,
  input wire logic [7:0]                    read_data,
  input wire logic [7:0]                    bias_trim_high,
  input wire logic                          raw_detect,
  input wire channel_ctrl_pkg::analog_ctrl_t analog_ctrl,
  input wire logic                          signal_present_status
);
  logic       live;
  logic [1:0] trim_lo;
  assign trim_lo = bias_trim_high[5:4];
  // First edge after reset still shows reset outputs, so skip it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) live <= 1'b0;
    else live <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_DRV: assert property (live && $past(read_addr) == 8'h06 |->
    {analog_ctrl.output_swing, analog_ctrl.common_mode_loop_disable, analog_ctrl.limiting_mode_select}
    == {read_data[7:6], read_data[2], read_data[0]}) else $error("driver fields wrong");
  AST_MUTE: assert property (live && $past(read_addr) == 8'h06 |->
    analog_ctrl.driver_mute == (read_data[4] ? read_data[1] : !signal_present_status)) else $error("mute wrong");
  AST_DPWR: assert property (live && $past(read_addr) == 8'h06 |->
    analog_ctrl.driver_power_down == (read_data[5] ? read_data[3] : !signal_present_status))
    else $error("driver power wrong");
  AST_THR: assert property (live && $past(read_addr) == 8'h05 |->
    {analog_ctrl.detect_assert_threshold, analog_ctrl.detect_deassert_threshold} == read_data[5:2])
    else $error("thresholds wrong");
  AST_FONE: assert property (live && $past(read_addr) == 8'h05 && read_data[7] |->
    signal_present_status) else $error("force one ignored");
  AST_FZERO: assert property (live && $past(read_addr) == 8'h05 && !read_data[7] |->
    signal_present_status == (!read_data[6] && $past(raw_detect))) else $error("detect wrong");
  AST_EQ: assert property (live && $past(read_addr) == 8'h04 |->
    {analog_ctrl.eq_gain_select, analog_ctrl.equalizer_bias_code, analog_ctrl.stage_one_bypass}
    == {read_data[5], read_data[1], $past(trim_lo), read_data[0]}) else $error("eq fields wrong");
  AST_STAT: assert property (live && $past(read_addr) == 8'h01 |->
    read_data == {signal_present_status, 7'h00}) else $error("status read wrong");
endmodule : channel_regs_chk
bind channel_eq_driver_control_regs channel_regs_chk u_chk (.clock(clock), .nrst(nrst),
  .read_addr(read_addr), .read_data(read_data), .bias_trim_high(bias_trim_high),
  .raw_detect(raw_detect), .analog_ctrl(analog_ctrl), .signal_present_status(signal_present_status));

// ===== dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  channel_ctrl_pkg::reg_write_t mgmt_write = '0;
  channel_ctrl_pkg::reg_write_t eeprom_write = '0;
  logic [7:0] read_addr = 8'h00, bias_trim_high = 8'h30, read_data, s04, s05, s06;
  logic raw_detect = 1'b1;
  logic signal_present_status;
  channel_ctrl_pkg::analog_ctrl_t analog_ctrl;
  int err_count = 0;
  int cmp_count = 0;
  always #50 clock = ~clock;
  channel_eq_driver_control_regs u_dut (.clock(clock), .nrst(nrst), .mgmt_write(mgmt_write),
    .read_addr(read_addr), .read_data(read_data), .eeprom_write(eeprom_write), .raw_detect(raw_detect),
    .bias_trim_high(bias_trim_high), .analog_ctrl(analog_ctrl), .signal_present_status(signal_present_status));
  ////////////////////////////////////////
  function automatic logic [15:0] model();
    logic off;
    off = ~(s05[7] | (~s05[6] & raw_detect));
    return {s04[5], s06[5] ? s04[3] : off, s04[1], bias_trim_high[5:4], s04[0], s05[5:2], s06[7:6],
      s06[5] ? s06[3] : off, s06[4] ? s06[1] : off, s06[2], s06[0]};
  endfunction : model
  task automatic chk_ctrl(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t analog controls got %h exp %h", $time, got, exp);
    end
  endtask : chk_ctrl
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t read data got %h exp %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t detect status got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic wrap_up;
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic do_reset;
    nrst = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    s04 = 8'h90;
    s05 = 8'h04;
    s06 = 8'hC0;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ee);
    @(negedge clock);
    if (ee) eeprom_write = '{1'b1, a, d};
    else mgmt_write = '{1'b1, a, d};
    @(negedge clock);
    mgmt_write.valid = 1'b0;
    eeprom_write.valid = 1'b0;
    if (a == 8'h04) s04 = d;
    if (a == 8'h05) s05 = d;
    if (a == 8'h06) s06 = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    read_addr = a;
    @(negedge clock);
    chk_data(read_data, exp);
  endtask : rd
  // Two edges: wr has already taken the write, one for the output flop, one spare
  task automatic settle_chk;
    @(negedge clock);
    @(negedge clock);
    chk_ctrl(analog_ctrl, model());
    chk_bit(signal_present_status, s05[7] | (~s05[6] & raw_detect));
  endtask : settle_chk
  ////////////////////////////////////////
  task automatic t_defaults;
    logic [7:0] adr [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h01};
    logic [7:0] dfl [7] = '{8'h90, 8'h04, 8'hC0, 8'h20, 8'h54, 8'h00, 8'h80};
    settle_chk();
    for (int i = 0; i < 7; i++) rd(adr[i], dfl[i]);
  endtask : t_defaults
  task automatic t_driver;
    wr(8'h04, 8'h2B, 1'b0);
    wr(8'h06, 8'h3F, 1'b0);
    settle_chk();
    raw_detect = 1'b0;
    bias_trim_high = 8'h10;
    settle_chk();
    wr(8'h06, 8'h02, 1'b0);
    settle_chk();
    raw_detect = 1'b1;
    settle_chk();
  endtask : t_driver
  task automatic t_detect;
    raw_detect = 1'b0;
    wr(8'h05, 8'hB8, 1'b0);
    settle_chk();
    rd(8'h01, 8'h80);
    raw_detect = 1'b1;
    wr(8'h05, 8'h70, 1'b0);
    settle_chk();
    rd(8'h01, 8'h00);
  endtask : t_detect
  task automatic t_eeprom;
    wr(8'h07, 8'hA5, 1'b1);
    rd(8'h07, 8'hA5);
    wr(8'h06, 8'h51, 1'b1);
    settle_chk();
    @(negedge clock);
    mgmt_write = '{1'b1, 8'h08, 8'h3C};
    eeprom_write = '{1'b1, 8'h08, 8'hC3};
    @(negedge clock);
    mgmt_write.valid = 1'b0;
    eeprom_write.valid = 1'b0;
    rd(8'h08, 8'h3C);
    wr(8'h01, 8'hFF, 1'b0);
    rd(8'h01, 8'h00);
  endtask : t_eeprom
  initial begin
    #5000000;
    err_count++;
    wrap_up();
  end
  initial begin
    do_reset();
    t_defaults();
    t_driver();
    t_detect();
    t_eeprom();
    do_reset();
    settle_chk();
    rd(8'h07, 8'h20);
    rd(8'h08, 8'h54);
    wrap_up();
  end
endmodule : tb_top
